//--- core/ibfc_pkg.sv
package ibfc_pkg;
	// ---------------------------------------------------------------
	// widths and constants
	// ---------------------------------------------------------------
	localparam int IBFC_CNT_W = 4; // transfer counter width
	localparam logic [3:0] IBFC_CNT_ZERO = 4'h0; // counter empty value
	localparam logic [3:0] IBFC_CNT_ONE = 4'h1; // decrement step
	localparam logic [3:0] IBFC_CNT_TWO = 4'h2; // two transfers left
	localparam logic [3:0] IBFC_CNT_THREE = 4'h3; // three transfers left
	localparam logic [1:0] IBFC_OVR_ZERO = 2'h0; // overrun counter floor
	localparam logic [1:0] IBFC_OVR_MAX = 2'h3; // overrun counter ceiling
	localparam int IBFC_STAT_W = 8; // extended status width
	localparam int IBFC_STAT_MABORT = 7; // master abort bit of status
	localparam int IBFC_STAT_TABORT = 6; // target abort bit of status
	localparam logic [7:0] IBFC_RETRY_LIMIT = 8'hff; // retries before giving up
	localparam logic [7:0] IBFC_RETRY_ZERO = 8'h00; // retry counter reset
	localparam logic [7:0] IBFC_RETRY_ONE = 8'h01; // retry step
	// controller states
	typedef enum logic [2:0] {
		IBFC_QUIESCENT,
		IBFC_REQUEST,
		IBFC_INBOUND,
		IBFC_OUTBOUND,
		IBFC_FAULT,
		IBFC_EVALUATE
	} ibfc_state_t;
endpackage : ibfc_pkg

//--- core/ibfc_ovr_if.sv
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------------------------
// overrun tracker connection
// ---------------------------------------------------------------
interface ibfc_ovr_if;
	logic advance; // anticipated transfer
	logic transferred; // actual transfer
	logic rewind; // fifo rewind pulse
	logic [1:0] count; // overrun count
	modport ctrl (output advance, output transferred, output rewind, input count);
	modport trk (input advance, input transferred, input rewind, output count);
endinterface : ibfc_ovr_if
`default_nettype wire

//--- core/ibfc_ovr_track.sv
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------------------------
// two-bit saturating up/down overrun counter
// ---------------------------------------------------------------
module ibfc_ovr_track
	import ibfc_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	ibfc_ovr_if.trk ovr
);
	logic [1:0] count_reg; // current count
	logic [1:0] count_next; // next count
	logic [2:0] sum; // count plus anticipated transfer
	logic [2:0] dec; // decrements in this cycle
	// next value: one up, two down, saturating
	// the net change is taken before clamping, so a full count that sees
	// an advance and a transfer together keeps its value
	always_comb begin
		sum = {1'b0, count_reg} + {2'b00, ovr.advance};
		dec = {2'b00, ovr.transferred} + {2'b00, ovr.rewind};
		if (sum <= dec) begin
			count_next = IBFC_OVR_ZERO;
		end else if ((sum - dec) > {1'b0, IBFC_OVR_MAX}) begin
			count_next = IBFC_OVR_MAX;
		end else begin
			count_next = sum[1:0] - dec[1:0];
		end
	end
	// register
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			count_reg <= IBFC_OVR_ZERO;
		end else begin
			count_reg <= count_next;
		end
	end
	assign ovr.count = count_reg;
endmodule // ibfc_ovr_track
`default_nettype wire

//--- core/ibfc_top.sv
// Functional notes
// - empty fifo write start is refused
// - full fifo read start is refused
// - almost empty finishes outbound transaction
// - almost full finishes inbound transaction
// - short transfers finish by counter only
// - refill or drain before next request
// - start never issued on empty/full
// - direction held; high means outbound
// - delayed data phase gives falling edge
// - abort flag cleared, loaded from status
// - re-request until zero, retry limit
// - 4-bit counter loads, decrements, done
// - counter untouched by fifo rewind
// - quiescent waits for start
// - request then branch on direction
// - stay in transfer until phase falls
// - abort goes fault, else evaluate
// - fault terminal until reset
// - evaluate rewinds, then idle or re-request
// - rewind undoes speculative reads; finish logic
// - fifo rewinds up to three reads
// - saturating overrun counter
// - rewind only in evaluate, nonzero count
`timescale 1ns/1ns
`default_nettype none
module ibfc_top
	import ibfc_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_start,
	input wire logic i_direction,
	input wire logic [3:0] i_burst_count_load,
	input wire logic i_long_transfer,
	input wire logic i_fifo_totally_empty,
	input wire logic i_fifo_totally_full,
	input wire logic i_fifo_almost_empty,
	input wire logic i_fifo_almost_full,
	input wire logic i_address_phase_n,
	input wire logic i_data_phase_active,
	input wire logic i_data_transferred,
	input wire logic i_source_advance,
	input wire logic i_target_retry,
	input wire logic [7:0] i_extended_status_bus,
	output logic o_request,
	output logic o_finish_request,
	output logic o_fifo_rewind,
	output logic o_write_not_read,
	output logic o_ready,
	output logic o_done,
	output logic o_busy,
	output logic o_fault,
	output logic o_start_refused,
	output logic o_retry_exhausted
);
	// ---------------------------------------------------------------
	// reset release
	// ---------------------------------------------------------------
	logic rst_meta_reg; // first release stage
	logic rst_sync_reg; // second release stage
	logic rst; // internal active-high reset
	// two-flop release of the asynchronous reset
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end
	assign rst = !rst_sync_reg;

	// ---------------------------------------------------------------
	// declarations
	// ---------------------------------------------------------------
	ibfc_state_t state_reg, state_next; // controller state
	logic dir_reg, dir_next; // latched direction
	logic [3:0] xfer_reg, xfer_next; // transfer counter
	logic dphase_q_reg, dphase_q_next; // delayed data phase
	logic abort_reg, abort_next; // abort flag
	logic hold_fin_reg, hold_fin_next; // held finish request
	logic [7:0] retry_reg, retry_next; // retry count
	logic exhaust_reg, exhaust_next; // retry limit reached
	logic refused_reg, refused_next; // start refused pulse
	logic ready_reg; // ready to transfer
	logic req_reg, fin_reg, rew_reg; // registered outputs
	logic done_reg, busy_reg, fault_reg;
	logic data_fell; // end of transaction
	logic done; // counter is zero
	logic start_ok; // start accepted
	logic flag_fin; // almost flag termination
	logic cnt_fin; // counter termination
	logic assert_fin; // new finish request
	logic rewind; // rewind in evaluate
	ibfc_ovr_if ovr (); // overrun tracker link

	// counter equality, used in several places
	function automatic logic ibfc_cnt_is(input logic [3:0] cnt, input logic [3:0] val);
		ibfc_cnt_is = (cnt == val);
	endfunction

	// a request the fifo cannot serve: write when empty, read when full
	function automatic logic ibfc_fifo_blocked(input logic wr,
		input logic empty, input logic full);
		ibfc_fifo_blocked = wr ? empty : full;
	endfunction

	// ---------------------------------------------------------------
	// combinational terms
	// ---------------------------------------------------------------
	// falling edge of data phase
	assign data_fell = dphase_q_reg & !i_data_phase_active;
	assign done = ibfc_cnt_is(xfer_reg, IBFC_CNT_ZERO);
	// refuse start on empty write or full read
	assign start_ok = i_start &&
		!ibfc_fifo_blocked(i_direction, i_fifo_totally_empty, i_fifo_totally_full);
	// almost flags only matter for long transfers
	assign flag_fin = i_long_transfer &&
		((state_reg == IBFC_OUTBOUND && i_fifo_almost_empty) ||
		(state_reg == IBFC_INBOUND && i_fifo_almost_full));
	// counter-based finish, pipelined by remaining count
	assign cnt_fin = (ibfc_cnt_is(xfer_reg, IBFC_CNT_ONE) && state_reg == IBFC_REQUEST) ||
		(ibfc_cnt_is(xfer_reg, IBFC_CNT_TWO) && dphase_q_reg) ||
		(ibfc_cnt_is(xfer_reg, IBFC_CNT_THREE) && i_data_transferred);
	assign assert_fin = cnt_fin || flag_fin;
	assign rewind = (state_reg == IBFC_EVALUATE) && (ovr.count != IBFC_OVR_ZERO);
	// anticipated transfers only when fifo not empty
	assign ovr.advance = i_source_advance & !i_fifo_totally_empty;
	assign ovr.transferred = i_data_transferred;
	assign ovr.rewind = rewind;

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	// computes the state machine and its companion registers
	always_comb begin
		state_next = state_reg;
		dir_next = dir_reg;
		xfer_next = xfer_reg;
		retry_next = retry_reg;
		exhaust_next = exhaust_reg;
		refused_next = 1'b0;
		dphase_q_next = i_data_phase_active;
		abort_next = abort_reg;
		if (!i_address_phase_n) begin
			abort_next = 1'b0;
		end else if (i_data_phase_active) begin
			abort_next = i_extended_status_bus[IBFC_STAT_MABORT] |
				i_extended_status_bus[IBFC_STAT_TABORT];
		end
		// held finish until the transaction ends
		hold_fin_next = hold_fin_reg;
		// a falling phase clears before a fresh finish term
		if (data_fell) begin
			hold_fin_next = 1'b0;
		end else if (assert_fin) begin
			hold_fin_next = 1'b1;
		end
		if (i_data_transferred && !done) begin
			xfer_next = xfer_reg - IBFC_CNT_ONE;
		end
		// state transitions
		unique case (state_reg)
			IBFC_QUIESCENT: begin
				if (start_ok) begin
					state_next = IBFC_REQUEST;
					dir_next = i_direction;
					xfer_next = i_burst_count_load;
					retry_next = IBFC_RETRY_ZERO;
					exhaust_next = 1'b0;
				end else if (i_start) begin
					refused_next = 1'b1;
				end
			end
			IBFC_REQUEST: begin
				state_next = dir_reg ? IBFC_OUTBOUND : IBFC_INBOUND;
			end
			IBFC_INBOUND, IBFC_OUTBOUND: begin
				if (data_fell) begin
					state_next = abort_reg ? IBFC_FAULT : IBFC_EVALUATE;
				end
				if (i_target_retry && retry_reg != IBFC_RETRY_LIMIT) begin
					retry_next = retry_reg + IBFC_RETRY_ONE;
				end
			end
			IBFC_FAULT: begin
				state_next = IBFC_FAULT;
			end
			IBFC_EVALUATE: begin
				// re-request only when fifo allows it
				if (!rewind) begin
					if (done) begin
						state_next = IBFC_QUIESCENT;
					end else if (retry_reg == IBFC_RETRY_LIMIT) begin
						// too many target retries: give up
						exhaust_next = 1'b1;
						state_next = IBFC_QUIESCENT;
					end else if (!ibfc_fifo_blocked(dir_reg, i_fifo_totally_empty,
						i_fifo_totally_full)) begin
						state_next = IBFC_REQUEST;
					end
				end
			end
			// illegal codes fall back to quiescent
			default: begin
				state_next = IBFC_QUIESCENT;
			end
		endcase
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	// asynchronous reset of state and counters
	always_ff @(posedge i_clk or posedge rst) begin
		if (rst) begin
			state_reg <= IBFC_QUIESCENT;
			dir_reg <= 1'b0;
			xfer_reg <= IBFC_CNT_ZERO;
			dphase_q_reg <= 1'b0;
			abort_reg <= 1'b0;
			hold_fin_reg <= 1'b0;
			retry_reg <= IBFC_RETRY_ZERO;
			exhaust_reg <= 1'b0;
			refused_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			dir_reg <= dir_next;
			xfer_reg <= xfer_next;
			dphase_q_reg <= dphase_q_next;
			abort_reg <= abort_next;
			hold_fin_reg <= hold_fin_next;
			retry_reg <= retry_next;
			exhaust_reg <= exhaust_next;
			refused_reg <= refused_next;
		end
	end

	// output flops, one cycle after their terms
	always_ff @(posedge i_clk or posedge rst) begin
		if (rst) begin
			ready_reg <= 1'b0;
			req_reg <= 1'b0;
			fin_reg <= 1'b0;
			rew_reg <= 1'b0;
			done_reg <= 1'b0;
			busy_reg <= 1'b0;
			fault_reg <= 1'b0;
		end else begin
			ready_reg <= 1'b1;
			req_reg <= (state_next == IBFC_REQUEST) && (state_reg != IBFC_REQUEST);
			fin_reg <= (assert_fin || hold_fin_next) && !data_fell;
			rew_reg <= rewind;
			done_reg <= done;
			busy_reg <= (state_next != IBFC_QUIESCENT);
			fault_reg <= (state_next == IBFC_FAULT);
		end
	end

	// ---------------------------------------------------------------
	// overrun tracker
	// ---------------------------------------------------------------
	ibfc_ovr_track u_ovr (
		.i_clk(i_clk),
		.i_rst(rst),
		.ovr(ovr)
	);

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	// every output comes straight from a flop
	assign o_request = req_reg;
	assign o_finish_request = fin_reg;
	assign o_fifo_rewind = rew_reg;
	assign o_write_not_read = dir_reg;
	assign o_ready = ready_reg;
	assign o_done = done_reg;
	assign o_busy = busy_reg;
	assign o_fault = fault_reg;
	assign o_start_refused = refused_reg;
	assign o_retry_exhausted = exhaust_reg;
endmodule // ibfc_top
`default_nettype wire

//--- bench/ibfc_top_chk.sv
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------------------------
// port checker for the burst controller
// ---------------------------------------------------------------
module ibfc_top_chk (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_address_phase_n,
	input wire logic i_data_phase_active,
	input wire logic [7:0] i_extended_status_bus,
	input wire logic o_request,
	input wire logic o_fifo_rewind,
	input wire logic o_write_not_read,
	input wire logic o_done,
	input wire logic o_busy,
	input wire logic o_fault,
	input wire logic o_start_refused,
	input wire logic o_retry_exhausted
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// last data phase carried an abort, then the phase fell
	sequence s_abort_end;
		i_data_phase_active && i_address_phase_n && (|i_extended_status_bus[7:6]) ##1 !i_data_phase_active;
	endsequence
	// controller busy for three cycles running
	sequence s_busy3;
		o_busy [*3];
	endsequence
	a_req_pulse: assert property (o_request |=> !o_request) else $error("request too wide");
	a_req_busy: assert property (o_request |-> o_busy) else $error("request while idle");
	a_abort_fault: assert property (s_abort_end |-> ##[1:4] o_fault) else $error("abort missed");
	a_fault_stays: assert property (o_fault |=> o_fault && !o_request) else $error("fault left");
	a_refuse_idle: assert property (o_start_refused |-> !o_busy && !o_request) else $error("bad refuse");
	a_rewind_eval: assert property (o_fifo_rewind |-> o_busy && !o_request) else $error("stray rewind");
	a_dir_stable: assert property (s_busy3 |-> $stable(o_write_not_read)) else $error("direction moved");
	a_done_idle: assert property ($fell(o_busy) |-> o_done || o_retry_exhausted) else $error("idle before done");
	a_xfer_noreq: assert property (i_data_phase_active |-> !o_request) else $error("request in phase");
endmodule // ibfc_top_chk
bind ibfc_top ibfc_top_chk u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n),
	.i_address_phase_n(i_address_phase_n), .i_data_phase_active(i_data_phase_active),
	.i_extended_status_bus(i_extended_status_bus), .o_request(o_request),
	.o_fifo_rewind(o_fifo_rewind), .o_write_not_read(o_write_not_read), .o_done(o_done),
	.o_busy(o_busy), .o_fault(o_fault), .o_start_refused(o_start_refused),
	.o_retry_exhausted(o_retry_exhausted));
`default_nettype wire

//--- bench/ibfc_core_model.sv
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------------------------
// behavioural bus core, initiator side
// ---------------------------------------------------------------
module ibfc_core_model (
	input wire logic i_clk,
	input wire logic i_request,
	input wire logic i_write,
	input wire logic i_abort,
	input wire logic [3:0] i_phases,
	output logic o_address_phase_n,
	output logic o_data_phase_active,
	output logic o_data_transferred,
	output logic o_source_advance,
	output logic o_target_retry,
	output logic [7:0] o_status
);
	int n; // data phases done in this transaction
	// one transaction per request, i_phases transfers long
	initial begin
		o_address_phase_n = 1'b1;
		o_data_phase_active = 1'b0;
		o_data_transferred = 1'b0;
		o_source_advance = 1'b0;
		o_target_retry = 1'b0;
		o_status = 8'h3c;
		forever begin
			@(posedge i_clk);
			if (i_request === 1'b1) begin
				repeat (2) @(posedge i_clk);
				o_address_phase_n <= 1'b0;
				@(posedge i_clk);
				o_address_phase_n <= 1'b1;
				n = 0;
				do begin
					o_data_phase_active <= 1'b1;
					o_data_transferred <= 1'b1;
					o_source_advance <= i_write;
					o_status <= {i_abort, 7'h00};
					@(posedge i_clk);
					n++;
				end while (n < i_phases);
				// speculative read that never transfers
				o_data_transferred <= 1'b0;
				@(posedge i_clk);
				o_data_phase_active <= 1'b0;
				o_source_advance <= 1'b0;
				@(posedge i_clk);
				o_status <= 8'h3c;
			end
		end
	end
endmodule // ibfc_core_model
`default_nettype wire

//--- bench/ibfc_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin num_errors++; $display("Error %s expected %0h seen %0h", n, e, a); end end
// ---------------------------------------------------------------
// self-checking bench
// ---------------------------------------------------------------
module ibfc_top_tb;
	logic i_clk = 1'b0, i_rst_n = 1'b0, i_start = 1'b0, i_direction = 1'b0;
	logic i_long_transfer = 1'b0, i_fifo_totally_empty = 1'b0, i_fifo_totally_full = 1'b0;
	logic i_fifo_almost_empty = 1'b0, i_fifo_almost_full = 1'b0, m_abort = 1'b0;
	logic [3:0] i_burst_count_load = 4'h0, m_phases = 4'h1;
	wire logic i_address_phase_n, i_data_phase_active, i_data_transferred, i_source_advance;
	wire logic i_target_retry;
	wire logic [7:0] i_extended_status_bus;
	logic o_request, o_finish_request, o_fifo_rewind, o_write_not_read, o_ready, o_done;
	logic o_busy, o_fault, o_start_refused, o_retry_exhausted;
	int num_errors = 0, checked = 0, n_req = 0, n_rew = 0, n_ref = 0, n_fin = 0;
	ibfc_top uut (.i_clk, .i_rst_n, .i_start, .i_direction, .i_burst_count_load, .i_long_transfer,
		.i_fifo_totally_empty, .i_fifo_totally_full, .i_fifo_almost_empty, .i_fifo_almost_full,
		.i_address_phase_n, .i_data_phase_active, .i_data_transferred, .i_source_advance,
		.i_target_retry, .i_extended_status_bus, .o_request, .o_finish_request, .o_fifo_rewind,
		.o_write_not_read, .o_ready, .o_done, .o_busy, .o_fault, .o_start_refused,
		.o_retry_exhausted);
	ibfc_core_model u_core (.i_clk(i_clk), .i_request(o_request), .i_write(i_direction),
		.i_abort(m_abort), .i_phases(m_phases), .o_address_phase_n(i_address_phase_n),
		.o_data_phase_active(i_data_phase_active), .o_data_transferred(i_data_transferred),
		.o_source_advance(i_source_advance), .o_target_retry(i_target_retry),
		.o_status(i_extended_status_bus));
	// clock, 50 ns period
	initial begin
		forever #25 i_clk = ~i_clk;
	end
	// count request, rewind and refusal pulses, and finish in any data phase of the first transaction
	always @(posedge i_clk) begin
		if (o_request === 1'b1) n_req++;
		if (o_fifo_rewind === 1'b1) n_rew++;
		if (o_start_refused === 1'b1) n_ref++;
		if (o_finish_request === 1'b1 && i_data_phase_active === 1'b1 && n_req == 1) n_fin++;
	end
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// reset for 20 cycles, then idle outputs
	task automatic do_reset;
		@(posedge i_clk);
		i_rst_n <= 1'b0;
		repeat (20) @(posedge i_clk);
		i_rst_n <= 1'b1;
		repeat (4) @(negedge i_clk);
		`CHK("busy", 1'b0, o_busy)
		`CHK("fault", 1'b0, o_fault)
		`CHK("done", 1'b1, o_done)
		`CHK("ready", 1'b1, o_ready)
		$display("reset test finished");
	endtask
	// one start pulse, then wait for idle or fault
	task automatic run(input logic d, input logic [3:0] l, input logic [3:0] ph, input logic ab);
		int k;
		@(posedge i_clk);
		n_req = 0;
		n_rew = 0;
		n_ref = 0;
		n_fin = 0;
		m_phases <= ph;
		m_abort <= ab;
		i_direction <= d;
		i_burst_count_load <= l;
		i_start <= 1'b1;
		@(posedge i_clk);
		i_start <= 1'b0;
		repeat (3) @(negedge i_clk);
		for (k = 0; k < 400 && o_busy === 1'b1 && o_fault !== 1'b1; k++) @(negedge i_clk);
		repeat (2) @(negedge i_clk);
	endtask
	task automatic t_write;
		run(1'b1, 4'h3, 4'h3, 1'b0);
		`CHK("dir", 1'b1, o_write_not_read)
		`CHK("requests", 1, n_req)
		`CHK("rewinds", 1, n_rew)
		`CHK("done", 1'b1, o_done)
		`CHK("finish", 1'b1, n_fin > 0)
		$display("write test finished");
	endtask
	task automatic t_read;
		run(1'b0, 4'h5, 4'h2, 1'b0);
		`CHK("dir", 1'b0, o_write_not_read)
		`CHK("requests", 3, n_req)
		`CHK("rewinds", 0, n_rew)
		`CHK("busy", 1'b0, o_busy)
		`CHK("early finish", 1'b0, n_fin > 0)
		`CHK("exhausted", 1'b0, o_retry_exhausted)
		$display("read test finished");
	endtask
	// full fifo read, then empty fifo write
	task automatic t_refuse;
		for (int d = 0; d < 2; d++) begin
			@(posedge i_clk);
			i_fifo_totally_full <= (d == 0);
			i_fifo_totally_empty <= (d == 1);
			run(d[0], 4'h2, 4'h2, 1'b0);
			`CHK("refused", 1, n_ref)
			`CHK("requests", 0, n_req)
		end
		@(posedge i_clk);
		i_fifo_totally_full <= 1'b0;
		i_fifo_totally_empty <= 1'b0;
		$display("refuse test finished");
	endtask
	// long read with almost full, then long write with almost empty
	task automatic t_long;
		for (int d = 0; d < 2; d++) begin
			@(posedge i_clk);
			i_long_transfer <= 1'b1;
			i_fifo_almost_full <= (d == 0);
			i_fifo_almost_empty <= (d == 1);
			run(d[0], 4'h5, 4'h2, 1'b0);
			`CHK("flag finish", 1'b1, n_fin > 0)
			`CHK("requests", 3, n_req)
			`CHK("rewinds", 3 * d, n_rew)
			`CHK("busy", 1'b0, o_busy)
		end
		@(posedge i_clk);
		i_long_transfer <= 1'b0;
		i_fifo_almost_full <= 1'b0;
		i_fifo_almost_empty <= 1'b0;
		$display("long test finished");
	endtask
	task automatic t_abort;
		run(1'b1, 4'h2, 4'h2, 1'b1);
		`CHK("fault", 1'b1, o_fault)
		repeat (10) @(negedge i_clk);
		`CHK("fault", 1'b1, o_fault)
		`CHK("requests", 1, n_req)
		@(posedge i_clk);
		m_abort <= 1'b0;
		do_reset;
		$display("abort test finished");
	endtask
	initial begin
		do_reset;
		t_write;
		t_read;
		t_refuse;
		t_long;
		t_abort;
		give_verdict;
	end
	// watchdog for a hung run
	initial begin
		repeat (20000) @(posedge i_clk);
		num_errors++;
		$display("Error watchdog expected finish seen timeout");
		give_verdict;
	end
endmodule // ibfc_top_tb
`default_nettype wire
